// file: src/spv_top.sv
// Segment pointer validation unit with an AHB-Lite register slave.
`timescale 1ns/10ps
module spv_top
  import spv_pkg::*;
#(
  parameter int ADDR_W = 8                 // Decoded address width.
)
(
  input  wire logic        hclk,           // Core clock, 25 MHz.
  input  wire logic        hresetn,        // Asynchronous reset, active low.
  input  wire logic        hsel,           // Slave select.
  input  wire logic [31:0] haddr,          // Byte address.
  input  wire logic [1:0]  htrans,         // Transfer type.
  input  wire logic        hwrite,         // Write when high.
  input  wire logic [2:0]  hsize,          // Transfer size, word only.
  input  wire logic [31:0] hwdata,         // Write data.
  input  wire logic        hready,         // Bus ready.
  output logic      [31:0] hrdata,         // Read data.
  output logic             hreadyout,      // Slave ready.
  output logic             hresp,          // Always OKAY.
  output logic             irq             // Level interrupt.
);

  if (ADDR_W < 6 || ADDR_W > 32)
  begin : g_chk
    $error("ADDR_W must lie between 6 and 32.");
  end

  spv_bus_st_t          bus_st_r;
  logic [7:0]           addr_r;
  logic                 wr_r;
  logic                 hready_r;
  logic [31:0]          hrdata_r;
  logic                 irq_r;
  logic [31:0]          ctrl_r;
  logic [15:0]          sel_r;
  logic [31:0]          dlo_r;
  logic [31:0]          dhi_r;
  logic [31:0]          tlim_r;
  logic [31:0]          dest_r;
  logic                 zero_flag_r;
  logic [SPV_ST_W-1:0]  stat_r;
  logic [SPV_ST_W-1:0]  mask_r;
  logic [31:0]          aaddr_r;
  logic                 wr_en;
  logic                 exec;
  logic [2:0]           op;

  // Selector and descriptor decode.
  logic [1:0]  current_priv_level;
  logic [1:0]  requester_priv_level;
  logic [1:0]  descriptor_priv_level;
  logic [3:0]  typ;
  logic        s_bit;
  logic        null_sel;
  logic        over_lim;
  logic        base_ok;
  logic        is_code;
  logic        is_conf;
  logic        is_data;
  logic        readable;
  logic        writable;
  logic        is_tss;
  logic        is_ldt;
  logic        is_cgate;
  logic        is_tgate;
  logic        visible;
  logic        rights_ok;
  logic        ver_ok;
  logic        limit_ok;
  logic        call_fault;
  logic        align_fault;
  logic [31:0] amask;
  logic [SPV_ST_W-1:0] ev;

  assign hrdata    = hrdata_r;
  assign hreadyout = hready_r;
  assign irq       = irq_r;

  // Limit scaling for the load limit path; its check recomputes the value on its own.
  function automatic logic [31:0] scaled_limit(input logic [31:0] hi, input logic [31:0] lo);
    logic [19:0] raw;
    raw = {hi[SPV_D_LIMHI_LSB+:4], lo[15:0]};
    if (hi[SPV_D_G_BIT])
      scaled_limit = {raw, 12'hfff}; // RULE_18
    else
      scaled_limit = {12'h000, raw};
    return scaled_limit;
  endfunction

  // Register read mux; unmapped offsets read as zero.
  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    if (a == SPV_CTRL_OFS) v = ctrl_r;
    else if (a == SPV_SEL_OFS) v = {16'h0000, sel_r};
    else if (a == SPV_DLO_OFS) v = dlo_r;
    else if (a == SPV_DHI_OFS) v = dhi_r;
    else if (a == SPV_TLIM_OFS) v = tlim_r;
    else if (a == SPV_DEST_OFS) v = dest_r;
    else if (a == SPV_RES_OFS) v = {31'h0, zero_flag_r};
    else if (a == SPV_STAT_OFS) v = {29'h0, stat_r};
    else if (a == SPV_MASK_OFS) v = {29'h0, mask_r};
    else if (a == SPV_AADDR_OFS) v = aaddr_r;
    return v;
  endfunction

  // Bus slave: every transfer gets one wait state so read data come from a flop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_st_r <= SPV_BUS_IDLE;
      addr_r   <= 8'h00;
      wr_r     <= 1'b0;
      hready_r <= 1'b1;
    end
    else
    begin
      case (bus_st_r)
        SPV_BUS_IDLE:
        begin
          if (hsel && htrans[1] && hready)
          begin
            bus_st_r <= SPV_BUS_DATA;
            addr_r   <= 8'({haddr[ADDR_W-1:2], 2'b00});
            wr_r     <= hwrite;
            hready_r <= 1'b0;
          end
        end
        SPV_BUS_DATA:
        begin
          bus_st_r <= SPV_BUS_IDLE;
          hready_r <= 1'b1;
        end
        default:
        begin
          bus_st_r <= SPV_BUS_IDLE;
          hready_r <= 1'b1;
        end
      endcase
    end
  end

  assign wr_en = (bus_st_r == SPV_BUS_DATA) && wr_r;
  assign exec  = wr_en && (addr_r == SPV_CMD_OFS) && (hwdata[2:0] != 3'h0);
  assign op    = hwdata[2:0];

  // Read data captured in the wait cycle; a read never sees a half-updated register.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_r <= 32'h0;
    else if (bus_st_r == SPV_BUS_DATA && !wr_r)
      hrdata_r <= rd_mux(addr_r);
  end

  // Plain software registers.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r  <= SPV_REG_RST;
      sel_r   <= 16'h0000;
      dlo_r   <= SPV_REG_RST;
      dhi_r   <= SPV_REG_RST;
      tlim_r  <= SPV_REG_RST;
      mask_r  <= SPV_ST_RST;
      aaddr_r <= SPV_REG_RST;
    end
    else if (wr_en)
    begin
      if (addr_r == SPV_CTRL_OFS) ctrl_r <= hwdata;
      else if (addr_r == SPV_SEL_OFS) sel_r <= hwdata[15:0];
      else if (addr_r == SPV_DLO_OFS) dlo_r <= hwdata;
      else if (addr_r == SPV_DHI_OFS) dhi_r <= hwdata;
      else if (addr_r == SPV_TLIM_OFS) tlim_r <= hwdata;
      else if (addr_r == SPV_MASK_OFS) mask_r <= hwdata[SPV_ST_W-1:0];
      else if (addr_r == SPV_AADDR_OFS) aaddr_r <= hwdata;
    end
  end

  // Descriptor classification and the common visibility test.
  always_comb
  begin
    current_priv_level    = ctrl_r[SPV_CTRL_CUR_PRIV_LSB+:2];
    requester_priv_level  = sel_r[1:0];
    descriptor_priv_level = dhi_r[SPV_D_DESC_PRIV_LSB+:2];
    typ      = dhi_r[SPV_D_TYPE_LSB+:4];
    s_bit    = dhi_r[SPV_D_S_BIT];
    null_sel = (sel_r[15:2] == 14'h0000); // RULE_03
    // The last byte of the eight-byte entry must lie within the table.
    over_lim = {1'b0, sel_r[15:3], 3'h7} > {1'b0, (sel_r[2] ? tlim_r[31:16] : tlim_r[15:0])}; // RULE_04
    base_ok  = !null_sel && !over_lim;
    is_code  = s_bit && typ[3];
    is_conf  = is_code && typ[2];
    is_data  = s_bit && !typ[3];
    readable = is_data || typ[1];
    writable = is_data && typ[1]; // RULE_11
    is_tss   = !s_bit && !typ[2] && typ[0];
    is_ldt   = !s_bit && (typ == 4'h2);
    is_cgate = !s_bit && (typ[2:0] == 3'h4);
    is_tgate = !s_bit && (typ == 4'h5);
    // Requester level weakens the caller, so both levels are held to the descriptor.
    visible  = is_conf || ((current_priv_level <= descriptor_priv_level)
                           && (requester_priv_level <= descriptor_priv_level)); // RULE_06 RULE_14
    rights_ok = base_ok && (s_bit || is_ldt || is_cgate || is_tgate || is_tss) && visible; // RULE_05
    ver_ok   = base_ok && s_bit && visible; // RULE_09
    limit_ok = base_ok && (s_bit || is_ldt || is_tss) && visible; // RULE_12
    call_fault = !base_ok || !(is_code || is_cgate || is_tgate || is_tss) // RULE_02
                 || (is_code && !is_conf && ((descriptor_priv_level != current_priv_level)
                 || (requester_priv_level > descriptor_priv_level))); // RULE_01
    amask    = (32'h1 << ctrl_r[SPV_CTRL_ASZ_LSB+:2]) - 32'h1;
    // Supervisor levels are exempt, whatever the two enables hold.
    align_fault = (current_priv_level == 2'h3) && ctrl_r[SPV_CTRL_CR_ALIGN_EN_BIT]
                  && ctrl_r[SPV_CTRL_FLAGS_ALIGN_BIT]
                  && ((aaddr_r & amask) != 32'h0); // RULE_16 RULE_17
  end

  // Destination register and zero flag; failed loads leave the destination alone.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dest_r <= SPV_REG_RST;
      zero_flag_r <= 1'b0;
    end
    else if (exec)
    begin
      case (op)
        SPV_OP_LOAD_RIGHTS:
        begin
          zero_flag_r <= rights_ok; // RULE_08
          if (rights_ok)
            dest_r <= dhi_r & SPV_RIGHTS_MASK; // RULE_07
        end
        SPV_OP_VERIFY_RD: zero_flag_r <= ver_ok && readable; // RULE_10
        SPV_OP_VERIFY_WR: zero_flag_r <= ver_ok && writable; // RULE_10
        SPV_OP_LOAD_LIMIT:
        begin
          zero_flag_r <= limit_ok; // RULE_08
          if (limit_ok)
            dest_r <= scaled_limit(dhi_r, dlo_r); // RULE_13
        end
        SPV_OP_ADJUST_REQ:
        begin
          zero_flag_r <= (dest_r[1:0] < requester_priv_level); // RULE_19
          if (dest_r[1:0] < requester_priv_level)
            dest_r[1:0] <= requester_priv_level; // RULE_15
        end
        default: zero_flag_r <= zero_flag_r;
      endcase
    end
    else if (wr_en && addr_r == SPV_DEST_OFS)
      dest_r <= hwdata;
  end

  // Sticky events; a set in the clearing cycle wins.
  always_comb
  begin
    ev = '0;
    ev[SPV_ST_DONE]  = exec;
    ev[SPV_ST_PROT]  = exec && (op == SPV_OP_CALL) && call_fault; // RULE_01 RULE_02
    ev[SPV_ST_ALIGN] = exec && (op == SPV_OP_ALIGN) && align_fault; // RULE_16
  end

  // Status bits clear on a written one; an event in the same cycle keeps its bit.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      stat_r <= SPV_ST_RST;
    else if (wr_en && addr_r == SPV_STAT_OFS)
      stat_r <= (stat_r & ~hwdata[SPV_ST_W-1:0]) | ev;
    else
      stat_r <= stat_r | ev;
  end

  // Interrupt follows the masked status one cycle late, keeping the pin glitch free.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(stat_r & mask_r);
  end

  // Response never signals an error.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  chk_null_rights_fails: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    exec && op == SPV_OP_LOAD_RIGHTS && sel_r[15:2] == 14'h0 |=> !zero_flag_r && $stable(dest_r))
    else $error("Null selector passed load access rights.");

  chk_null_other_fails: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
    exec && (op == SPV_OP_LOAD_LIMIT || op == SPV_OP_VERIFY_RD || op == SPV_OP_VERIFY_WR)
    && sel_r[15:2] == 14'h0 |=> !zero_flag_r)
    else $error("Null selector passed a check operation.");

  chk_limit_fails: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_04
    exec && op == SPV_OP_VERIFY_RD && over_lim |=> !zero_flag_r)
    else $error("Selector beyond table limit passed verify readable.");

  chk_limit_keeps_dest: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_08
    exec && op == SPV_OP_LOAD_LIMIT && !limit_ok |=> !zero_flag_r && dest_r == $past(dest_r))
    else $error("Failed load limit changed destination or zero flag.");

  chk_rights_loads_mask: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
    exec && op == SPV_OP_LOAD_RIGHTS && rights_ok |=> zero_flag_r && dest_r == ($past(dhi_r) & SPV_RIGHTS_MASK))
    else $error("Load access rights result wrong.");

  chk_rights_type: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
    exec && op == SPV_OP_LOAD_RIGHTS && !s_bit
    && typ inside {4'h0, 4'h6, 4'h7, 4'h8, 4'ha, 4'hd, 4'he, 4'hf} |=> !zero_flag_r)
    else $error("Unsupported system type passed load access rights.");

  chk_level_visible: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_06
    exec && op == SPV_OP_LOAD_RIGHTS && !(s_bit && typ[3] && typ[2])
    && current_priv_level > descriptor_priv_level |=> !zero_flag_r)
    else $error("Invisible descriptor passed load access rights.");

  chk_verify_type: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_09
    exec && op == SPV_OP_VERIFY_RD && !s_bit |=> !zero_flag_r)
    else $error("System descriptor passed verify readable.");

  chk_readable_only: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
    exec && op == SPV_OP_VERIFY_RD && s_bit && typ[3] && !typ[1] |=> !zero_flag_r)
    else $error("Execute-only code reported readable.");

  chk_writable_code: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
    exec && op == SPV_OP_VERIFY_WR && dhi_r[SPV_D_S_BIT] && dhi_r[SPV_D_TYPE_LSB+3] |=> !zero_flag_r)
    else $error("Code segment reported writable.");

  chk_limit_gate: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_12
    exec && op == SPV_OP_LOAD_LIMIT && (is_cgate || is_tgate) |=> !zero_flag_r)
    else $error("Gate passed load segment limit.");

  chk_limit_scaled: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13 RULE_18
    exec && op == SPV_OP_LOAD_LIMIT && limit_ok |=> zero_flag_r && dest_r == ($past(dhi_r[SPV_D_G_BIT])
      ? {$past(dhi_r[SPV_D_LIMHI_LSB+:4]), $past(dlo_r[15:0]), 12'hfff}
      : {12'h000, $past(dhi_r[SPV_D_LIMHI_LSB+:4]), $past(dlo_r[15:0])}))
    else $error("Load segment limit result wrong.");

  chk_requester_denies: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14
    exec && op == SPV_OP_VERIFY_RD && is_data && requester_priv_level > descriptor_priv_level |=> !zero_flag_r)
    else $error("Requester level above descriptor level was granted.");

  chk_adjust_raises: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15
    exec && op == SPV_OP_ADJUST_REQ && dest_r[1:0] < requester_priv_level
    |=> zero_flag_r && dest_r[1:0] == $past(requester_priv_level))
    else $error("Adjust requester did not raise the field.");

  chk_adjust_keeps: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
    exec && op == SPV_OP_ADJUST_REQ && dest_r[1:0] >= requester_priv_level |=> !zero_flag_r && $stable(dest_r))
    else $error("Adjust requester changed a field that was high enough.");

  chk_call_fault: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
    exec && op == SPV_OP_CALL && base_ok && is_code && !is_conf
    && descriptor_priv_level != current_priv_level |=> stat_r[SPV_ST_PROT])
    else $error("Far call privilege mismatch not flagged.");

  chk_type_call: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_02
    exec && op == SPV_OP_CALL && s_bit && !typ[3] |=> stat_r[SPV_ST_PROT])
    else $error("Far call to a data segment not flagged.");

  chk_align_odd: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
    exec && op == SPV_OP_ALIGN && current_priv_level == 2'h3 && ctrl_r[SPV_CTRL_CR_ALIGN_EN_BIT]
    && ctrl_r[SPV_CTRL_FLAGS_ALIGN_BIT] && aaddr_r[0] && ctrl_r[SPV_CTRL_ASZ_LSB+:2] != 2'h0
    |=> stat_r[SPV_ST_ALIGN])
    else $error("Odd address at level 3 raised no alignment fault.");

  chk_no_low_align: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_17
    exec && op == SPV_OP_ALIGN && current_priv_level != 2'h3 && !stat_r[SPV_ST_ALIGN] |=> !stat_r[SPV_ST_ALIGN])
    else $error("Alignment fault raised below level 3.");

  chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 irq == |($past(stat_r) & $past(mask_r)))
    else $error("Interrupt does not follow masked status.");

endmodule

// file: src/spv_pkg.sv
// Constants, types and register map of the segment pointer validation block.
// What this block does
// [RULE_01] Far call to nonconforming code needs descriptor level equal current, requester not above it.
// [RULE_02] Far call accepts only code, call gate, task gate or task state segment types.
// [RULE_03] Every check operation fails first when the selector is null.
// [RULE_04] Every check fails when the selector index lies beyond its table limit.
// [RULE_05] Load access rights accepts code, data, local table, gates or task state segment.
// [RULE_06] Unless conforming code, current and requester levels must not exceed descriptor level.
// [RULE_07] Load access rights success loads masked second doubleword and sets the zero flag.
// [RULE_08] Failed load access rights or load limit keeps destination and clears zero flag.
// [RULE_09] Verify readable and writable accept only code or data descriptors.
// [RULE_10] Zero flag set only if visible and readable, or visible and writable.
// [RULE_11] Code segments are never writable, so verify writable on code fails.
// [RULE_12] Load limit accepts code, data, local table or task state; gates fail.
// [RULE_13] Load limit success loads the scaled limit and sets the zero flag.
// [RULE_14] Requester level above data descriptor level denies access whatever the current level.
// [RULE_15] Adjust requester raises destination requester field to source value when lower.
// [RULE_16] Level 3 with both alignment enables set faults on unaligned references.
// [RULE_17] Levels 0, 1 and 2 never raise alignment faults.
// [RULE_18] Granular limit is raw limit shifted left twelve with low twelve bits ones.
// [RULE_19] Adjust requester sets zero flag when it changes the field, else clears it.
package spv_pkg;

  // Register byte offsets.
  localparam logic [7:0] SPV_CTRL_OFS  = 8'h00;
  localparam logic [7:0] SPV_SEL_OFS   = 8'h04;
  localparam logic [7:0] SPV_DLO_OFS   = 8'h08;
  localparam logic [7:0] SPV_DHI_OFS   = 8'h0c;
  localparam logic [7:0] SPV_TLIM_OFS  = 8'h10;
  localparam logic [7:0] SPV_CMD_OFS   = 8'h14;
  localparam logic [7:0] SPV_DEST_OFS  = 8'h18;
  localparam logic [7:0] SPV_RES_OFS   = 8'h1c;
  localparam logic [7:0] SPV_STAT_OFS  = 8'h20;
  localparam logic [7:0] SPV_MASK_OFS  = 8'h24;
  localparam logic [7:0] SPV_AADDR_OFS = 8'h28;

  // Control register fields.
  localparam int SPV_CTRL_CUR_PRIV_LSB    = 0;
  localparam int SPV_CTRL_CR_ALIGN_EN_BIT = 2;
  localparam int SPV_CTRL_FLAGS_ALIGN_BIT = 3;
  localparam int SPV_CTRL_ASZ_LSB         = 4;

  // Descriptor high doubleword fields.
  localparam int SPV_D_TYPE_LSB      = 8;
  localparam int SPV_D_S_BIT         = 12;
  localparam int SPV_D_DESC_PRIV_LSB = 13;
  localparam int SPV_D_LIMHI_LSB     = 16;
  localparam int SPV_D_G_BIT         = 23;

  // Status and mask bit positions.
  localparam int SPV_ST_DONE  = 0;
  localparam int SPV_ST_PROT  = 1;
  localparam int SPV_ST_ALIGN = 2;
  localparam int SPV_ST_W     = 3;

  // Operation codes written to the command register.
  localparam logic [2:0] SPV_OP_LOAD_RIGHTS = 3'h1;
  localparam logic [2:0] SPV_OP_VERIFY_RD   = 3'h2;
  localparam logic [2:0] SPV_OP_VERIFY_WR   = 3'h3;
  localparam logic [2:0] SPV_OP_LOAD_LIMIT  = 3'h4;
  localparam logic [2:0] SPV_OP_ADJUST_REQ  = 3'h5;
  localparam logic [2:0] SPV_OP_CALL        = 3'h6;
  localparam logic [2:0] SPV_OP_ALIGN       = 3'h7;

  // Access rights mask; the undefined nibble passes through.
  localparam logic [31:0] SPV_RIGHTS_MASK = 32'h00ffff00;

  // Reset values.
  localparam logic [31:0]       SPV_REG_RST  = 32'h0;
  localparam logic [SPV_ST_W-1:0] SPV_ST_RST = 3'h0;

  typedef enum logic {SPV_BUS_IDLE, SPV_BUS_DATA} spv_bus_st_t;

endpackage

// file: verif/spv_pipe_model.sv
// Bus master model of the pipeline that hands operands and commands to the block.
`timescale 1ns/10ps
module spv_pipe_model
(
  input  wire logic        hclk,   // Core clock.
  output logic             hsel,   // Slave select.
  output logic      [31:0] haddr,  // Byte address.
  output logic      [1:0]  htrans, // Transfer type.
  output logic             hwrite, // Write when high.
  output logic      [2:0]  hsize,  // Always a word.
  output logic      [31:0] hwdata, // Write data.
  input  wire logic        hready, // Bus ready.
  input  wire logic [31:0] hrdata  // Read data.
);
  // Idle bus at time zero.
  initial
  begin
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // Waits for hready high at a rising edge, with a bound so a dead slave cannot hang us.
  task automatic wait_rdy(inout bit to);
    int n;
    begin
      n = 0;
      do
      begin
        @(posedge hclk);
        n++;
      end
      while (hready !== 1'b1 && n < 40);
      if (hready !== 1'b1)
        to = 1'b1;
    end
  endtask

  // One single word transfer, entered just after a rising edge. The write data is
  // inverted once the data phase ends, so a stale value never passes for fresh data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit to);
    begin
      to = 1'b0;
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy(to);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy(to);
      q = hrdata;
      hwdata <= ~d;
    end
  endtask
endmodule

// file: verif/segment_pointer_validation_test.sv
// Self-checking bench: a table of check operations, then interrupt, bus and reset cases.
`timescale 1ns/10ps
module segment_pointer_validation_test
  import spv_pkg::*;
;
  localparam logic [31:0] D0 = 32'h11111111;

  typedef struct packed
  {
    logic [2:0]  op;
    logic [7:0]  ctrl;
    logic [15:0] sel;
    logic [31:0] dhi;
    logic [31:0] dst;
    logic        zf;
    logic        f;
  } spv_row_t;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  int          err_count;
  int          n_tests;

  // Operation, level and enables, selector, descriptor, expected DEST, zero flag, fault.
  spv_row_t rows [0:30] = '{
    '{3'h1,8'h0,16'h9,32'hab05f212,32'h5f200,1'b1,1'b0},
    '{3'h1,8'h0,16'h3,32'hab05f212,D0,1'b0,1'b0},
    '{3'h4,8'h0,16'h2,32'hab05f212,D0,1'b0,1'b0},
    '{3'h1,8'h0,16'hc,32'hab05f212,D0,1'b0,1'b0},
    '{3'h1,8'h0,16'h8,32'he000,D0,1'b0,1'b0},
    '{3'h1,8'h0,16'h8,32'hec00,32'hec00,1'b1,1'b0},
    '{3'h1,8'h3,16'h8,32'h9200,D0,1'b0,1'b0},
    '{3'h2,8'h0,16'hb,32'h9200,D0,1'b0,1'b0},
    '{3'h2,8'h3,16'hb,32'h9e00,D0,1'b1,1'b0},
    '{3'h2,8'h0,16'h8,32'hec00,D0,1'b0,1'b0},
    '{3'h2,8'h0,16'h8,32'hf800,D0,1'b0,1'b0},
    '{3'h3,8'h0,16'h8,32'hf200,D0,1'b1,1'b0},
    '{3'h3,8'h0,16'h8,32'hf000,D0,1'b0,1'b0},
    '{3'h3,8'h0,16'h8,32'hfa00,D0,1'b0,1'b0},
    '{3'h4,8'h0,16'h8,32'hab05f212,32'h51234,1'b1,1'b0},
    '{3'h4,8'h0,16'h8,32'hab85f212,32'h51234fff,1'b1,1'b0},
    '{3'h4,8'h0,16'h8,32'hec00,D0,1'b0,1'b0},
    '{3'h4,8'h0,16'h8,32'he900,32'h1234,1'b1,1'b0},
    '{3'h5,8'h0,16'hb,32'h0,32'h11111113,1'b1,1'b0},
    '{3'h5,8'h0,16'h8,32'h0,D0,1'b0,1'b0},
    '{3'h6,8'h2,16'ha,32'hda00,D0,1'b0,1'b0},
    '{3'h6,8'h1,16'h9,32'hda00,D0,1'b0,1'b1},
    '{3'h6,8'h2,16'hb,32'hda00,D0,1'b0,1'b1},
    '{3'h6,8'h0,16'h8,32'hf200,D0,1'b0,1'b1},
    '{3'h6,8'h0,16'h8,32'he500,D0,1'b0,1'b0},
    '{3'h6,8'h0,16'h8,32'he900,D0,1'b0,1'b0},
    '{3'h7,8'h2f,16'h1,32'h0,D0,1'b0,1'b1},
    '{3'h7,8'h2e,16'h1,32'h0,D0,1'b0,1'b0},
    '{3'h7,8'h2c,16'h1,32'h0,D0,1'b0,1'b0},
    '{3'h7,8'h2f,16'h4,32'h0,D0,1'b0,1'b0},
    '{3'h7,8'h27,16'h1,32'h0,D0,1'b0,1'b0}
  };

  spv_top #(.ADDR_W(8)) i_spv_top
  (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .irq       (irq)
  );

  spv_pipe_model i_spv_pipe_model
  (
    .hclk   (hclk),
    .hsel   (hsel),
    .haddr  (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize  (hsize),
    .hwdata (hwdata),
    .hready (hreadyout),
    .hrdata (hrdata)
  );

  // Free-running core clock, 40 ns period.
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  task automatic tally_and_finish();
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    begin
      n_tests++;
      if (s !== e)
      begin
        $display("[FAIL] %s expected %h seen %h", name, e, s);
        err_count++;
      end
    end
  endtask

  // A bus transfer; a read compares its data with d. A stuck slave ends the run.
  task automatic io(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bit          to;
    begin
      i_spv_pipe_model.xfer(w, a, d, q, to);
      if (to)
      begin
        err_count++;
        tally_and_finish();
      end
      else if (!w)
        check($sformatf("reg %h", a), d, q);
    end
  endtask

  // The interrupt is registered, so it is looked at one edge after the write lands.
  task automatic irq_is(input logic e);
    begin
      @(posedge hclk);
      check("irq", {31'h0, e}, {31'h0, irq});
    end
  endtask

  initial
  begin
    err_count = 0;
    n_tests   = 0;
    hresetn   = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Each row loads operands, issues the command and reads back every result.
    foreach (rows[i])
    begin
      io(1'b1, SPV_CTRL_OFS, {24'h0, rows[i].ctrl});
      io(1'b1, SPV_SEL_OFS, {16'h0, rows[i].sel});
      io(1'b1, SPV_AADDR_OFS, {16'h0, rows[i].sel});
      io(1'b1, SPV_DLO_OFS, 32'h1234);
      io(1'b1, SPV_DHI_OFS, rows[i].dhi);
      io(1'b1, SPV_TLIM_OFS, 32'h000e000f);
      io(1'b1, SPV_DEST_OFS, D0);
      io(1'b1, SPV_CMD_OFS, {29'h0, rows[i].op});
      io(1'b0, SPV_DEST_OFS, rows[i].dst);
      io(1'b0, SPV_RES_OFS, {31'h0, rows[i].zf});
      io(1'b0, SPV_STAT_OFS, {29'h0, rows[i].op == 3'h7 && rows[i].f, rows[i].op == 3'h6 && rows[i].f, 1'b1});
      io(1'b1, SPV_STAT_OFS, 32'h7);
      $display("Test row %0d done", i);
    end
    // Interrupt raised by an alignment fault, masked, unmasked and cleared.
    io(1'b1, SPV_MASK_OFS, 32'h4);
    io(1'b1, SPV_CTRL_OFS, 32'h2f);
    io(1'b1, SPV_AADDR_OFS, 32'h2);
    io(1'b1, SPV_CMD_OFS, 32'h7);
    irq_is(1'b1);
    io(1'b1, SPV_MASK_OFS, 32'h0);
    irq_is(1'b0);
    io(1'b1, SPV_MASK_OFS, 32'h5);
    irq_is(1'b1);
    io(1'b1, SPV_STAT_OFS, 32'h7);
    irq_is(1'b0);
    io(1'b0, SPV_MASK_OFS, 32'h5);
    $display("Test interrupt done");
    // Unmapped offset drops writes and reads zero; the command register reads zero.
    io(1'b1, 8'h3c, 32'hffffffff);
    io(1'b0, 8'h3c, 32'h0);
    io(1'b0, SPV_CMD_OFS, 32'h0);
    check("hresp", 32'h0, {31'h0, hresp});
    $display("Test bus done");
    // Reset in mid-run with the interrupt pending clears the interrupt, control, destination, result, status and mask.
    io(1'b1, SPV_CMD_OFS, 32'h7);
    irq_is(1'b1);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check("irq in reset", 32'h0, {31'h0, irq});
    check("hreadyout in reset", 32'h1, {31'h0, hreadyout});
    hresetn <= 1'b1;
    @(posedge hclk);
    io(1'b0, SPV_CTRL_OFS, 32'h0);
    io(1'b0, SPV_DEST_OFS, 32'h0);
    io(1'b0, SPV_RES_OFS, 32'h0);
    io(1'b0, SPV_STAT_OFS, 32'h0);
    io(1'b0, SPV_MASK_OFS, 32'h0);
    $display("Test reset done");
    tally_and_finish();
  end
endmodule
